// >>> verilog/mii_rmii_map.vh
`ifndef MII_RMII_MAP_VH
`define MII_RMII_MAP_VH

// ----------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------
// System clock period in ns
`define SYS_CLK_PERIOD_NS 4
// Shared reference clock rate in MHz
`define REF_CLK_MHZ 50
// MAC clock rates, in kHz
`define MAC_CLK_10M_KHZ 2500
`define MAC_CLK_100M_KHZ 25000

// ----------------------------------------------------------------
// Reference cycles per line symbol
// ----------------------------------------------------------------
// Reference cycles per MAC clock half period, derived from the rates
`define DIV_100M (`REF_CLK_MHZ * 1000 / `MAC_CLK_100M_KHZ / 2)
`define DIV_10M (`REF_CLK_MHZ * 1000 / `MAC_CLK_10M_KHZ / 2)
// Counter limits as 4-bit values
`define DIV_100M_LAST 4'h0
`define DIV_10M_LAST 4'h9
// Receive sample point within a symbol (mid symbol at 10 Mbps)
`define SAMPLE_100M 4'h0
`define SAMPLE_10M 4'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DIV_RESET 4'h0
`define NIBBLE_RESET 4'h0
`define DIBIT_RESET 2'h0

`endif

// >>> verilog/mac_clock_gen.v
`timescale 1ns/1ns
`include "mii_rmii_map.vh"

// Makes the MAC-side clock from reference clock edges and marks
// the symbol steps that the data paths follow.
module mac_clock_gen
(
   input wire sys_clk,
   input wire rst,
   input wire ref_rise,
   input wire speed_100_req,
   output reg mac_clk_reg,
   output reg step_rise,
   output reg step_fall,
   output reg sample_pulse,
   output reg speed_100_reg
);

   // Reference cycles seen within the current half period
   reg [3:0] div_reg;
   // Last count of a half period for the speed in force
   wire [3:0] div_last;
   // Receive sample slot for the speed in force
   wire [3:0] sample_pt;

   assign div_last = speed_100_reg ? `DIV_100M_LAST : `DIV_10M_LAST;
   assign sample_pt = speed_100_reg ? `SAMPLE_100M : `SAMPLE_10M;

   // ----------------------------------------------------------------
   // Divider and glitch-free rate switch
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= `DIV_RESET;
         mac_clk_reg <= 1'b0;
         step_rise <= 1'b0;
         step_fall <= 1'b0;
         sample_pulse <= 1'b0;
         speed_100_reg <= 1'b0;
      end
      else
      begin
         // Pulses last one system cycle
         step_rise <= 1'b0;
         step_fall <= 1'b0;
         sample_pulse <= 1'b0;
         if (ref_rise)
         begin
            sample_pulse <= (div_reg == sample_pt);
            if (div_reg == div_last)
            begin
               div_reg <= `DIV_RESET;
               mac_clk_reg <= ~mac_clk_reg;
               if (!mac_clk_reg)
               begin
                  step_rise <= 1'b1;
                  speed_100_reg <= speed_100_req;
               end
               else
               begin
                  step_fall <= 1'b1;
               end
            end
            else
            begin
               div_reg <= div_reg + 4'h1;
            end
         end
      end
   end

endmodule

// >>> verilog/mii_to_rmii_adapter.v
`timescale 1ns/1ns
`include "mii_rmii_map.vh"

module mii_to_rmii_adapter
(
   input wire sys_clk,
   input wire rst,
   input wire ref_clk,
   input wire speed_100,
   input wire [3:0] mac_txd,
   input wire mac_tx_en,
   input wire mac_tx_er,
   output wire mac_tx_clk,
   output wire mac_rx_clk,
   output reg [3:0] mac_rxd,
   output reg mac_rx_dv,
   output reg mac_rx_er,
   input wire [1:0] rmii_rxd,
   input wire rmii_crs_dv,
   input wire rmii_rx_er,
   output reg [1:0] rmii_txd,
   output reg rmii_tx_en
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Reference clock stages; third stage feeds the edge detector
   reg ref_s1_reg;
   reg ref_s2_reg;
   reg ref_s3_reg;
   // Speed select stages
   reg speed_s1_reg;
   reg speed_s2_reg;
   // MAC transmit group stages
   reg [5:0] tx_s1_reg;
   reg [5:0] tx_s2_reg;
   // PHY receive group stages
   reg [3:0] rx_s1_reg;
   reg [3:0] rx_s2_reg;

   // All pins are asynchronous to sys_clk, so every one gets two flops, the reference clock three.
   // The transmit group is captured long after the MAC launch, so
   // the bits have settled well before the sync stages sample them.
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
         ref_s3_reg <= 1'b0;
         speed_s1_reg <= 1'b0;
         speed_s2_reg <= 1'b0;
         tx_s1_reg <= 6'h00;
         tx_s2_reg <= 6'h00;
         rx_s1_reg <= 4'h0;
         rx_s2_reg <= 4'h0;
      end
      else
      begin
         ref_s1_reg <= ref_clk;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         speed_s1_reg <= speed_100;
         speed_s2_reg <= speed_s1_reg;
         tx_s1_reg <= {mac_tx_er, mac_tx_en, mac_txd};
         tx_s2_reg <= tx_s1_reg;
         rx_s1_reg <= {rmii_rx_er, rmii_crs_dv, rmii_rxd};
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Reference edge and MAC clock generation
   // ----------------------------------------------------------------
   // One-cycle pulse at each reference rising edge
   wire ref_rise;
   // Generated MAC clock
   wire mac_clk;
   // Start of a MAC clock period
   wire step_rise;
   // Middle of a MAC clock period
   wire step_fall;
   // Receive sample slot
   wire sample_pulse;
   // Speed currently in force
   wire speed_100_cur;

   assign ref_rise = ref_s2_reg & ~ref_s3_reg;

   mac_clock_gen clk_gen
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .ref_rise(ref_rise),
      .speed_100_req(speed_s2_reg),
      .mac_clk_reg(mac_clk),
      .step_rise(step_rise),
      .step_fall(step_fall),
      .sample_pulse(sample_pulse),
      .speed_100_reg(speed_100_cur)
   );

   assign mac_tx_clk = mac_clk;
   // Receive clock is the same flop; both directions share one rate
   assign mac_rx_clk = mac_clk;

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   // Upper dibit held back for the second half period
   reg [1:0] tx_hi_reg;
   // Enable captured with the nibble
   reg tx_en_hold_reg;

   // A nibble is captured at each rising MAC clock, the low pair goes
   // out at once and the high pair at mid period. At 10 Mbps each half
   // period is ten reference cycles, so each dibit stands for ten.
   // An error nibble is sent as is; the PHY has no error input here.
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_hi_reg <= `DIBIT_RESET;
         tx_en_hold_reg <= 1'b0;
         rmii_txd <= `DIBIT_RESET;
         rmii_tx_en <= 1'b0;
      end
      else if (step_rise)
      begin
         tx_en_hold_reg <= tx_s2_reg[4];
         // Idle nibbles drive zeros rather than stale data
         tx_hi_reg <= tx_s2_reg[4] ? tx_s2_reg[3:2] : `DIBIT_RESET;
         rmii_txd <= tx_s2_reg[4] ? tx_s2_reg[1:0] : `DIBIT_RESET;
         rmii_tx_en <= tx_s2_reg[4];
      end
      else if (step_fall)
      begin
         rmii_txd <= tx_hi_reg;
         rmii_tx_en <= tx_en_hold_reg;
      end
   end

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   // Low dibit waiting for its partner
   reg [1:0] rx_lo_reg;
   // Set once the low dibit of a nibble is held
   reg rx_half_reg;
   // Error seen on the low dibit
   reg rx_er_lo_reg;
   // Nibble assembled, waiting for the falling MAC edge
   reg [3:0] rx_nib_reg;
   reg rx_dv_nib_reg;
   reg rx_er_nib_reg;
   // Previous sample saw no carrier
   reg rx_idle_reg;

   // Samples one dibit per symbol; at 10 Mbps that is mid symbol, so
   // nine of ten oversampled copies are ignored. Pairing restarts
   // whenever carrier drops, which realigns the nibble at preamble.
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_lo_reg <= `DIBIT_RESET;
         rx_half_reg <= 1'b0;
         rx_er_lo_reg <= 1'b0;
         rx_nib_reg <= `NIBBLE_RESET;
         rx_dv_nib_reg <= 1'b0;
         rx_er_nib_reg <= 1'b0;
         rx_idle_reg <= 1'b1;
      end
      else if (sample_pulse)
      begin
         if (!rx_s2_reg[2])
         begin
            // No carrier: drop any half nibble
            rx_half_reg <= 1'b0;
            rx_idle_reg <= 1'b1;
            // Last nibble lives one more sample, else a MAC fall may miss it
            if (rx_idle_reg)
            begin
               rx_nib_reg <= `NIBBLE_RESET;
               rx_dv_nib_reg <= 1'b0;
               rx_er_nib_reg <= 1'b0;
            end
         end
         else if (!rx_half_reg)
         begin
            rx_lo_reg <= rx_s2_reg[1:0];
            rx_er_lo_reg <= rx_s2_reg[3];
            rx_half_reg <= 1'b1;
            rx_idle_reg <= 1'b0;
            // A new frame retires the old frame's nibble at once
            if (rx_idle_reg)
            begin
               rx_dv_nib_reg <= 1'b0;
            end
         end
         else
         begin
            rx_nib_reg <= {rx_s2_reg[1:0], rx_lo_reg};
            rx_dv_nib_reg <= 1'b1;
            rx_er_nib_reg <= rx_er_lo_reg | rx_s2_reg[3];
            rx_half_reg <= 1'b0;
            rx_idle_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // MAC receive outputs
   // ----------------------------------------------------------------
   // Outputs change on the falling MAC edge so the MAC, sampling on
   // its rising edge, sees a full half period of setup.
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         mac_rxd <= `NIBBLE_RESET;
         mac_rx_dv <= 1'b0;
         mac_rx_er <= 1'b0;
      end
      else if (step_fall)
      begin
         mac_rxd <= rx_nib_reg;
         mac_rx_dv <= rx_dv_nib_reg;
         mac_rx_er <= rx_er_nib_reg;
      end
   end

endmodule

// >>> testbench/adapter_sva.sv
`timescale 1ns/1ns
// ---
// Port checker
// ---
module adapter_sva
(
   input wire sys_clk,
   input wire rst,
   input wire ref_clk,
   input wire [3:0] mac_txd,
   input wire mac_tx_en,
   input wire mac_tx_clk,
   input wire mac_rx_clk,
   input wire [3:0] mac_rxd,
   input wire mac_rx_dv,
   input wire mac_rx_er,
   input wire [1:0] rmii_txd,
   input wire rmii_tx_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Cycles since the MAC clock moved; starts saturated so reset is no runt
   reg [9:0] run_reg;
   // Reference rises per MAC phase; 1f marks the unmeasured first phase
   reg [4:0] refs_reg;
   // Nibble taken at the last MAC rise
   reg [3:0] nib_reg;
   // Helper counters and the captured nibble
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         run_reg <= 10'h3ff;
         refs_reg <= 5'h1f;
         nib_reg <= 4'h0;
      end
      else
      begin
         run_reg <= $changed(mac_tx_clk) ? 10'h0 : run_reg + {9'h0, run_reg != 10'h3ff};
         if ($changed(mac_tx_clk))
            refs_reg <= 5'h0;
         else if ($rose(ref_clk) && refs_reg != 5'h1f)
            refs_reg <= refs_reg + 5'h1;
         if ($rose(mac_tx_clk))
            nib_reg <= $past(mac_tx_en, 2) ? $past(mac_txd, 2) : 4'h0;
      end
   end
   a_rx_clk_same: assert property (mac_rx_clk == mac_tx_clk)
      else $error("rx clock differs");
   a_no_runt: assert property ($changed(mac_tx_clk) |-> run_reg >= 10'h1c)
      else $error("runt on mac clock");
   a_phase_refs: assert property ($changed(mac_tx_clk) |->
      refs_reg inside {5'h1, 5'h0a, 5'h1f}) else $error("mac phase length wrong");
   a_tx_en_take: assert property ($rose(mac_tx_clk) |=> rmii_tx_en == $past(mac_tx_en, 3))
      else $error("tx enable not taken");
   a_tx_low_first: assert property ($rose(mac_tx_clk) |=> rmii_txd == nib_reg[1:0])
      else $error("low dibit wrong");
   a_tx_high_next: assert property ($fell(mac_tx_clk) |=> rmii_txd == nib_reg[3:2])
      else $error("high dibit wrong");
   a_txd_stands: assert property (!$changed(mac_tx_clk) |=> $stable(rmii_txd))
      else $error("dibit moved mid phase");
   a_rx_on_fall: assert property (!$fell(mac_rx_clk) |=>
      $stable({mac_rxd, mac_rx_dv, mac_rx_er})) else $error("rx moved off falling edge");
   cover property ($rose(mac_rx_dv));
   cover property ($rose(rmii_tx_en));
   cover property ($changed(mac_tx_clk) && refs_reg == 5'h0a);
endmodule
bind mii_to_rmii_adapter adapter_sva chk (.sys_clk, .rst, .ref_clk, .mac_txd, .mac_tx_en,
   .mac_tx_clk, .mac_rx_clk, .mac_rxd, .mac_rx_dv, .mac_rx_er, .rmii_txd, .rmii_tx_en);

// >>> testbench/phy_model.sv
`timescale 1ns/1ns
// ---
// Far side line device
// ---
module phy_model
(
   input wire ref_clk,
   output logic [1:0] rmii_rxd = 2'h0,
   output logic rmii_crs_dv = 1'h0,
   output logic rmii_rx_er = 1'h0
);
   // Reference cycles per dibit, 1 or 10, set by the bench
   integer hold_cycles = 10;
   // Sends n nibbles as one frame; changes on the falling reference edge
   // so the adapter never samples a moving line
   task automatic send(input logic [7:0] data, input integer n, input logic er);
      integer i;
      integer k;
      begin
         for (i = 0; i < 2 * n; i++)
         begin
            @(negedge ref_clk);
            rmii_rxd = data[2 * i +: 2];
            rmii_crs_dv = 1'h1;
            rmii_rx_er = er;
            for (k = 1; k < hold_cycles; k++)
               @(negedge ref_clk);
         end
         @(negedge ref_clk);
         // Released line shows the inverse, not a stale value
         rmii_rxd = ~rmii_rxd;
         rmii_crs_dv = 1'h0;
         rmii_rx_er = 1'h0;
      end
   endtask
endmodule

// >>> testbench/mii_to_rmii_adapter_bench.sv
`timescale 1ns/1ns
`define check(w, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s expected %h seen %h", w, e, g); end end
// ---
// Adapter bench
// ---
module mii_to_rmii_adapter_bench;
   typedef struct {logic sp; logic [3:0] nib; logic en; logic er; logic [1:0] lo, hi;} row_t;
   logic sys_clk = 1'h0, ref_clk = 1'h0, rst = 1'h1, speed_100 = 1'h1;
   logic [3:0] mac_txd = 4'h0;
   logic mac_tx_en = 1'h0, mac_tx_er = 1'h0;
   wire mac_tx_clk, mac_rx_clk, mac_rx_dv, mac_rx_er, rmii_crs_dv, rmii_rx_er, rmii_tx_en;
   wire [3:0] mac_rxd;
   wire [1:0] rmii_rxd, rmii_txd;
   integer n_errors = 0, samples_checked = 0, cycles = 0, r;
   // Received nibbles, error flag on top
   logic [4:0] rx_q[$];
   logic rx_prev = 1'h0;
   logic rx_fell = 1'h0;
   // Speed, nibble, enable, error, expected low and high dibits
   row_t rows[5] = '{'{1'h1, 4'h6, 1'h1, 1'h0, 2'h2, 2'h1}, '{1'h1, 4'h9, 1'h1, 1'h1, 2'h1, 2'h2},
      '{1'h1, 4'hc, 1'h0, 1'h0, 2'h0, 2'h0}, '{1'h0, 4'h3, 1'h1, 1'h1, 2'h3, 2'h0},
      '{1'h0, 4'he, 1'h1, 1'h0, 2'h2, 2'h3}};
   mii_to_rmii_adapter uut (.sys_clk, .rst, .ref_clk, .speed_100, .mac_txd, .mac_tx_en,
      .mac_tx_er, .mac_tx_clk, .mac_rx_clk, .mac_rxd, .mac_rx_dv, .mac_rx_er, .rmii_rxd,
      .rmii_crs_dv, .rmii_rx_er, .rmii_txd, .rmii_tx_en);
   phy_model phy (.ref_clk, .rmii_rxd, .rmii_crs_dv, .rmii_rx_er);
   initial forever #2 sys_clk = ~sys_clk;
   // Board reference; some edges meet system edges, so it moves by non-blocking update
   initial
   begin
      forever
      begin
         #63 ref_clk <= 1'h1;
         #62 ref_clk <= 1'h0;
      end
   end
   // Watchdog: a hang counts as a mismatch
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_errors++;
         close_out;
      end
   end
   // Collect each nibble one cycle after a falling receive clock, once it is shown
   always @(negedge sys_clk)
   begin
      if (rx_fell && mac_rx_dv === 1'h1)
         rx_q.push_back({mac_rx_er, mac_rxd});
      rx_fell = rx_prev && !mac_rx_clk;
      rx_prev = mac_rx_clk;
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Called just after a MAC fall, as the MAC itself launches data
   task automatic tx_nib(input row_t w);
      begin
         mac_txd = w.nib;
         mac_tx_en = w.en;
         mac_tx_er = w.er;
         // Line outputs follow the MAC clock edge by one system cycle
         @(posedge mac_tx_clk);
         repeat (2) @(negedge sys_clk);
         `check("tx low", w.lo, rmii_txd)
         `check("tx enable", w.en, rmii_tx_en)
         @(negedge mac_tx_clk);
         repeat (2) @(negedge sys_clk);
         `check("tx high", w.hi, rmii_txd)
      end
   endtask
   initial
   begin
      repeat (5) @(negedge sys_clk);
      rst = 1'h0;
      for (r = 0; r < 5; r++)
      begin
         @(negedge sys_clk);
         speed_100 = rows[r].sp;
         phy.hold_cycles = rows[r].sp ? 1 : 10;
         repeat (2) @(negedge mac_tx_clk);
         @(negedge sys_clk);
         tx_nib(rows[r]);
         mac_tx_en = 1'h0;
         rx_q.delete();
         phy.send({4'h0, rows[r].nib}, 1, rows[r].er);
         repeat (3) @(negedge mac_rx_clk);
         `check("rx nibble", {rows[r].er, rows[r].nib}, rx_q[0])
         $display("row %0d done", r);
      end
      // Back-to-back nibbles right after a switch back to 100 Mbps
      @(negedge sys_clk);
      speed_100 = 1'h1;
      phy.hold_cycles = 1;
      repeat (2) @(negedge mac_tx_clk);
      @(negedge sys_clk);
      tx_nib('{1'h1, 4'h1, 1'h1, 1'h0, 2'h1, 2'h0});
      tx_nib('{1'h1, 4'h8, 1'h1, 1'h0, 2'h0, 2'h2});
      mac_tx_en = 1'h0;
      // Two-nibble frame pairs low dibit first
      rx_q.delete();
      phy.send(8'h5a, 2, 1'h0);
      repeat (3) @(negedge mac_rx_clk);
      `check("rx first", 5'h0a, rx_q[0])
      `check("rx second", 5'h05, rx_q[1])
      $display("pair test done");
      // Reset while a frame arrives clears the MAC clock, receive nibble and valid, and line transmit outputs
      fork
         phy.send(8'hc3, 2, 1'h1);
      join_none
      repeat (70) @(negedge sys_clk);
      rst = 1'h1;
      @(negedge sys_clk);
      `check("reset outs", 9'h0, {mac_tx_clk, mac_rx_dv, mac_rxd, rmii_txd, rmii_tx_en})
      repeat (4) @(negedge sys_clk);
      rst = 1'h0;
      repeat (2) @(negedge mac_tx_clk);
      @(negedge sys_clk);
      tx_nib(rows[0]);
      $display("reset test done");
      close_out;
   end
endmodule
